// [src/svm_pkg.sv]
// ***************************************************************
// voltage monitor shared constants
// ***************************************************************
package svm_pkg;

  // ***************************************************************
  // register byte offsets on the bus
  // ***************************************************************
  localparam logic [11:0] ADDR_PROTECT  = 12'h000;
  localparam logic [11:0] ADDR_CLOCK    = 12'h004;
  localparam logic [11:0] ADDR_CONTROL  = 12'h008;
  localparam logic [11:0] ADDR_FLAG     = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_EN   = 12'h010;
  localparam int          ADDR_BITS     = 12;

  // ***************************************************************
  // key and codes
  // ***************************************************************
  localparam logic [15:0] PROTECT_KEY       = 16'h0096;
  localparam logic [3:0]  RESET_SELECT_CODE = 4'ha;
  localparam logic [1:0]  MODE_CONTINUOUS   = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic [2:0]  HSIZE_WORD        = 3'h2;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CLK_SRC_LSB   = 0;
  localparam int CLK_DIV_LSB   = 4;
  localparam int CLK_DEBUG_RUN_BIT = 8;
  localparam int CTL_EN_BIT    = 0;
  localparam int CTL_MODE_LSB  = 2;
  localparam int CTL_SEL_LSB   = 4;
  localparam int CTL_THR_LSB   = 8;
  localparam int CTL_SUCC_LSB  = 13;
  localparam int CTL_SRC_BIT   = 15;
  localparam int FLAG_BIT      = 0;
  localparam int RESULT_BIT    = 8;
  localparam int IRQ_EN_BIT    = 0;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [1:0]  CLK_SRC_RESET   = 2'h0;
  localparam logic [2:0]  CLK_DIV_RESET   = 3'h0;
  localparam logic        DEBUG_RUN_RESET     = 1'b1;
  localparam logic [4:0]  THR_RESET       = 5'h00;
  localparam logic [3:0]  SEL_RESET       = 4'h0;
  localparam logic [1:0]  SUCC_RESET      = 2'h0;

  // ***************************************************************
  // intermittent intervals in monitor ticks, per mode 1..3
  // ***************************************************************
  localparam logic [15:0] INTERVAL_MODE1  = 16'h0100;
  localparam logic [15:0] INTERVAL_MODE2  = 16'h0400;
  localparam logic [15:0] INTERVAL_MODE3  = 16'h1000;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } svm_bus_e;

endpackage : svm_pkg

// [src/svm_clock_gate.sv]
`timescale 1ns/1ps
// ***************************************************************
// monitor clock: source pick, divide, sleep and debug gating
// ***************************************************************
module svm_clock_gate #(
  parameter int DIV_BITS = 3
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic [3:0]          sourceTick,
  input  wire logic [3:0]          sourceSleepStop,
  input  wire logic [1:0]          clockSourceSel,
  input  wire logic [DIV_BITS-1:0] clockDividerSel,
  input  wire logic                sleepMode,
  input  wire logic                debugMode,
  input  wire logic                debugRun,
  output logic                     monitorTick
);

  logic [(1<<DIV_BITS)-1:0] divCount_r;
  logic [(1<<DIV_BITS)-1:0] divCount_nxt;
  logic                     tick_r;
  logic                     tick_nxt;
  logic                     stopped;

  generate
    if (DIV_BITS < 1 || DIV_BITS > 4) begin : badDivBits
      $error("svm_clock_gate: DIV_BITS out of range");
    end
  endgenerate

  // halted source keeps the divider where it stood, nothing lost on wake
  always_comb begin
    stopped = (sleepMode && sourceSleepStop[clockSourceSel])
              || (debugMode && !debugRun);
    divCount_nxt = divCount_r;
    tick_nxt     = 1'b0;
    if (!stopped && sourceTick[clockSourceSel]) begin
      if (divCount_r >= ((1<<DIV_BITS)'(1) << clockDividerSel) - 1'b1) begin
        divCount_nxt = '0;
        tick_nxt     = 1'b1;
      end else begin
        divCount_nxt = divCount_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      divCount_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      divCount_r <= divCount_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign monitorTick = tick_r;

endmodule : svm_clock_gate

// [src/svm_detector.sv]
`timescale 1ns/1ps
// ***************************************************************
// sampling of comparator, interval timing, successive low count
// ***************************************************************
module svm_detector (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       monitorTick,
  input  wire logic       detectEnable,
  input  wire logic [1:0] operatingMode,
  input  wire logic [1:0] successiveLowCount,
  input  wire logic       compLow,
  output logic            lowSupplyResult,
  output logic            lowEvent
);

  logic [15:0] interval_r;
  logic [15:0] interval_nxt;
  logic [3:0]  lowRun_r;
  logic [3:0]  lowRun_nxt;
  logic        result_r;
  logic        result_nxt;
  logic        event_r;
  logic        event_nxt;
  logic        sampleNow;

  // interval length for an intermittent mode
  function automatic logic [15:0] intervalOf(input logic [1:0] mode);
    case (mode)
      2'h1:    intervalOf = svm_pkg::INTERVAL_MODE1;
      2'h2:    intervalOf = svm_pkg::INTERVAL_MODE2;
      default: intervalOf = svm_pkg::INTERVAL_MODE3;
    endcase
  endfunction : intervalOf

  // required run of lows: 1, 2, 4 or 8
  function automatic logic [3:0] needOf(input logic [1:0] code);
    needOf = 4'h1 << code;
  endfunction : needOf

  // continuous samples every tick; intermittent only at interval end
  always_comb begin
    interval_nxt = interval_r;
    lowRun_nxt   = lowRun_r;
    result_nxt   = result_r;
    event_nxt    = 1'b0;
    sampleNow    = 1'b0;
    if (!detectEnable) begin
      interval_nxt = '0;
      lowRun_nxt   = '0;
    end else if (monitorTick) begin
      if (operatingMode == svm_pkg::MODE_CONTINUOUS) begin
        sampleNow    = 1'b1;
        interval_nxt = '0;
      end else if (interval_r >= intervalOf(operatingMode) - 16'h0001) begin
        sampleNow    = 1'b1;
        interval_nxt = '0;
      end else begin
        interval_nxt = interval_r + 16'h0001;
      end
    end
    if (sampleNow) begin
      result_nxt = compLow;
      if (operatingMode == svm_pkg::MODE_CONTINUOUS) begin
        lowRun_nxt = '0;
        event_nxt  = compLow;
      end else if (!compLow) begin
        lowRun_nxt = '0;
      end else if (lowRun_r + 4'h1 >= needOf(successiveLowCount)) begin
        lowRun_nxt = '0;
        event_nxt  = 1'b1;
      end else begin
        lowRun_nxt = lowRun_r + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      interval_r <= '0;
      lowRun_r   <= '0;
      result_r   <= 1'b0;
      event_r    <= 1'b0;
    end else begin
      interval_r <= interval_nxt;
      lowRun_r   <= lowRun_nxt;
      result_r   <= result_nxt;
      event_r    <= event_nxt;
    end
  end

  assign lowSupplyResult = result_r;
  assign lowEvent        = event_r;

endmodule : svm_detector

// [src/svm_monitor_top.sv]
`timescale 1ns/1ps
// Functional notes
// - key 0x0096 unlocks protected settings
// - one bit picks supply or sense pin
// - five-bit threshold, thirty-two levels
// - result readable; low triggers interrupt or reset
// - single low-supply interrupt output
// - two-bit mode: continuous or three intervals
// - intermittent needs programmed successive lows
// - clock source and divider fields, protected
// - sleep-stop source halts monitor, state held
// - debug-run zero gates clock in debug
// - debug-run one keeps running in debug
// - flag cleared by writing one
// - select code 0xa means reset, else interrupt
// - mode zero continuous, one to three intermittent
// - result one means below threshold
// - flag sticky; request only when enabled
module svm_monitor_top #(
  parameter int DIV_BITS = 3
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        compLow,
  input  wire logic [3:0]  sourceTick,
  input  wire logic [3:0]  sourceSleepStop,
  input  wire logic        sleepMode,
  input  wire logic        debugMode,
  output logic             senseSourceSelect,
  output logic [4:0]       thresholdLevel,
  output logic             compEnable,
  output logic             lowSupplyIrq,
  output logic             monitorResetReq
);

  // ***************************************************************
  // state
  // ***************************************************************
  svm_pkg::svm_bus_e             busState_r;
  svm_pkg::svm_bus_e             busState_nxt;
  logic [svm_pkg::ADDR_BITS-1:0] busAddr_r;
  logic [svm_pkg::ADDR_BITS-1:0] busAddr_nxt;
  logic                          busWord_r;
  logic                          busWord_nxt;
  logic                          hreadyout_r;
  logic                          hreadyout_nxt;
  logic [31:0]                   hrdata_r;
  logic [31:0]                   hrdata_nxt;

  logic [15:0]                   protectKey_r;
  logic [15:0]                   protectKey_nxt;
  logic [1:0]                    clockSourceSel_r;
  logic [1:0]                    clockSourceSel_nxt;
  logic [DIV_BITS-1:0]           clockDividerSel_r;
  logic [DIV_BITS-1:0]           clockDividerSel_nxt;
  logic                          debugRun_r;
  logic                          debugRun_nxt;

  logic                          detectEnable_r;
  logic                          detectEnable_nxt;
  logic [1:0]                    operatingMode_r;
  logic [1:0]                    operatingMode_nxt;
  logic [3:0]                    resetOrIrqSel_r;
  logic [3:0]                    resetOrIrqSel_nxt;
  logic [4:0]                    threshold_r;
  logic [4:0]                    threshold_nxt;
  logic [1:0]                    successiveLow_r;
  logic [1:0]                    successiveLow_nxt;
  logic                          senseSel_r;
  logic                          senseSel_nxt;

  logic                          lowFlag_r;
  logic                          lowFlag_nxt;
  logic                          irqEnable_r;
  logic                          irqEnable_nxt;
  logic                          irqOut_r;
  logic                          irqOut_nxt;
  logic                          resetReq_r;
  logic                          resetReq_nxt;
  logic                          compEnable_r;
  logic                          compEnable_nxt;

  logic                          monitorTick;
  logic                          lowSupplyResult;
  logic                          lowEvent;
  logic                          accept;
  logic                          unlocked;
  logic                          doWrite;

  generate
    if (DIV_BITS != 3) begin : badDivBits
      $error("svm_monitor_top: divider field is three bits wide");
    end
  endgenerate

  // ***************************************************************
  // monitor clock and detector
  // ***************************************************************
  svm_clock_gate #(
    .DIV_BITS (DIV_BITS)
  ) uClockGate (
    .mclk            (mclk),
    .reset           (reset),
    .sourceTick      (sourceTick),
    .sourceSleepStop (sourceSleepStop),
    .clockSourceSel  (clockSourceSel_r),
    .clockDividerSel (clockDividerSel_r),
    .sleepMode       (sleepMode),
    .debugMode       (debugMode),
    .debugRun        (debugRun_r),
    .monitorTick     (monitorTick)
  );

  svm_detector uDetector (
    .mclk               (mclk),
    .reset              (reset),
    .monitorTick        (monitorTick),
    .detectEnable       (detectEnable_r),
    .operatingMode      (operatingMode_r),
    .successiveLowCount (successiveLow_r),
    .compLow            (compLow),
    .lowSupplyResult    (lowSupplyResult),
    .lowEvent           (lowEvent)
  );

  // ***************************************************************
  // bus slave: writes zero-wait, reads one wait state
  // ***************************************************************
  // the read wait state lets a write just before it land first
  always_comb begin
    accept        = hsel && hready && htrans[1];
    busState_nxt  = svm_pkg::BUS_IDLE;
    busAddr_nxt   = busAddr_r;
    busWord_nxt   = busWord_r;
    hreadyout_nxt = 1'b1;
    hrdata_nxt    = hrdata_r;
    if (busState_r == svm_pkg::BUS_READ) begin
      hrdata_nxt = '0;
      case (busAddr_r)
        svm_pkg::ADDR_PROTECT: begin
          hrdata_nxt[15:0] = protectKey_r;
        end
        svm_pkg::ADDR_CLOCK: begin
          hrdata_nxt[svm_pkg::CLK_SRC_LSB +: 2]        = clockSourceSel_r;
          hrdata_nxt[svm_pkg::CLK_DIV_LSB +: DIV_BITS] = clockDividerSel_r;
          hrdata_nxt[svm_pkg::CLK_DEBUG_RUN_BIT]           = debugRun_r;
        end
        svm_pkg::ADDR_CONTROL: begin
          hrdata_nxt[svm_pkg::CTL_EN_BIT]        = detectEnable_r;
          hrdata_nxt[svm_pkg::CTL_MODE_LSB +: 2] = operatingMode_r;
          hrdata_nxt[svm_pkg::CTL_SEL_LSB +: 4]  = resetOrIrqSel_r;
          hrdata_nxt[svm_pkg::CTL_THR_LSB +: 5]  = threshold_r;
          hrdata_nxt[svm_pkg::CTL_SUCC_LSB +: 2] = successiveLow_r;
          hrdata_nxt[svm_pkg::CTL_SRC_BIT]       = senseSel_r;
        end
        svm_pkg::ADDR_FLAG: begin
          hrdata_nxt[svm_pkg::FLAG_BIT]   = lowFlag_r;
          hrdata_nxt[svm_pkg::RESULT_BIT] = lowSupplyResult;
        end
        svm_pkg::ADDR_IRQ_EN: begin
          hrdata_nxt[svm_pkg::IRQ_EN_BIT] = irqEnable_r;
        end
        default: begin
          hrdata_nxt = '0;
        end
      endcase
    end else if (accept) begin
      busAddr_nxt = {haddr[svm_pkg::ADDR_BITS-1:2], 2'b00};
      busWord_nxt = (hsize == svm_pkg::HSIZE_WORD) && (haddr[31:svm_pkg::ADDR_BITS] == '0);
      if (hwrite) begin
        busState_nxt = svm_pkg::BUS_WRITE;
      end else begin
        busState_nxt  = svm_pkg::BUS_READ;
        hreadyout_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busState_r  <= svm_pkg::BUS_IDLE;
      busAddr_r   <= '0;
      busWord_r   <= 1'b0;
      hreadyout_r <= 1'b1;
      hrdata_r    <= '0;
    end else begin
      busState_r  <= busState_nxt;
      busAddr_r   <= busAddr_nxt;
      busWord_r   <= busWord_nxt;
      hreadyout_r <= hreadyout_nxt;
      hrdata_r    <= hrdata_nxt;
    end
  end

  // ***************************************************************
  // registers and low-supply handling
  // ***************************************************************
  // protected fields take bus writes only when the key is in place
  always_comb begin
    doWrite             = (busState_r == svm_pkg::BUS_WRITE) && busWord_r;
    unlocked            = (protectKey_r == svm_pkg::PROTECT_KEY);
    protectKey_nxt      = protectKey_r;
    clockSourceSel_nxt  = clockSourceSel_r;
    clockDividerSel_nxt = clockDividerSel_r;
    debugRun_nxt        = debugRun_r;
    detectEnable_nxt    = detectEnable_r;
    operatingMode_nxt   = operatingMode_r;
    resetOrIrqSel_nxt   = resetOrIrqSel_r;
    threshold_nxt       = threshold_r;
    successiveLow_nxt   = successiveLow_r;
    senseSel_nxt        = senseSel_r;
    irqEnable_nxt       = irqEnable_r;
    lowFlag_nxt         = lowFlag_r;
    resetReq_nxt        = resetReq_r;
    if (doWrite && busAddr_r == svm_pkg::ADDR_PROTECT) begin
      protectKey_nxt = hwdata[15:0];
    end
    if (doWrite && unlocked && busAddr_r == svm_pkg::ADDR_CLOCK) begin
      clockSourceSel_nxt  = hwdata[svm_pkg::CLK_SRC_LSB +: 2];
      clockDividerSel_nxt = hwdata[svm_pkg::CLK_DIV_LSB +: DIV_BITS];
      debugRun_nxt        = hwdata[svm_pkg::CLK_DEBUG_RUN_BIT];
    end
    if (doWrite && unlocked && busAddr_r == svm_pkg::ADDR_CONTROL) begin
      detectEnable_nxt  = hwdata[svm_pkg::CTL_EN_BIT];
      operatingMode_nxt = hwdata[svm_pkg::CTL_MODE_LSB +: 2];
      resetOrIrqSel_nxt = hwdata[svm_pkg::CTL_SEL_LSB +: 4];
      threshold_nxt     = hwdata[svm_pkg::CTL_THR_LSB +: 5];
      successiveLow_nxt = hwdata[svm_pkg::CTL_SUCC_LSB +: 2];
      senseSel_nxt      = hwdata[svm_pkg::CTL_SRC_BIT];
    end
    if (doWrite && busAddr_r == svm_pkg::ADDR_IRQ_EN) begin
      irqEnable_nxt = hwdata[svm_pkg::IRQ_EN_BIT];
    end
    // flag: write-one clears, but a same-cycle event wins
    if (doWrite && busAddr_r == svm_pkg::ADDR_FLAG && hwdata[svm_pkg::FLAG_BIT]) begin
      lowFlag_nxt = 1'b0;
    end
    if (lowEvent) begin
      lowFlag_nxt = 1'b1;
      if (resetOrIrqSel_r == svm_pkg::RESET_SELECT_CODE) begin
        resetReq_nxt = 1'b1;
      end
    end
    // reset state: forced continuous, clock settings back to defaults
    if (resetReq_r) begin
      operatingMode_nxt   = svm_pkg::MODE_CONTINUOUS;
      successiveLow_nxt   = svm_pkg::SUCC_RESET;
      irqEnable_nxt       = 1'b0;
      clockSourceSel_nxt  = svm_pkg::CLK_SRC_RESET;
      clockDividerSel_nxt = DIV_BITS'(svm_pkg::CLK_DIV_RESET);
      debugRun_nxt        = svm_pkg::DEBUG_RUN_RESET;
      if (!lowSupplyResult && !lowEvent) begin
        resetReq_nxt = 1'b0;
      end
    end
    irqOut_nxt     = lowFlag_nxt && irqEnable_nxt
                     && (resetOrIrqSel_nxt != svm_pkg::RESET_SELECT_CODE);
    compEnable_nxt = detectEnable_nxt;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      protectKey_r      <= '0;
      clockSourceSel_r  <= svm_pkg::CLK_SRC_RESET;
      clockDividerSel_r <= DIV_BITS'(svm_pkg::CLK_DIV_RESET);
      debugRun_r        <= svm_pkg::DEBUG_RUN_RESET;
      detectEnable_r    <= 1'b0;
      operatingMode_r   <= svm_pkg::MODE_CONTINUOUS;
      resetOrIrqSel_r   <= svm_pkg::SEL_RESET;
      threshold_r       <= svm_pkg::THR_RESET;
      successiveLow_r   <= svm_pkg::SUCC_RESET;
      senseSel_r        <= 1'b0;
      lowFlag_r         <= 1'b0;
      irqEnable_r       <= 1'b0;
      irqOut_r          <= 1'b0;
      resetReq_r        <= 1'b0;
      compEnable_r      <= 1'b0;
    end else begin
      protectKey_r      <= protectKey_nxt;
      clockSourceSel_r  <= clockSourceSel_nxt;
      clockDividerSel_r <= clockDividerSel_nxt;
      debugRun_r        <= debugRun_nxt;
      detectEnable_r    <= detectEnable_nxt;
      operatingMode_r   <= operatingMode_nxt;
      resetOrIrqSel_r   <= resetOrIrqSel_nxt;
      threshold_r       <= threshold_nxt;
      successiveLow_r   <= successiveLow_nxt;
      senseSel_r        <= senseSel_nxt;
      lowFlag_r         <= lowFlag_nxt;
      irqEnable_r       <= irqEnable_nxt;
      irqOut_r          <= irqOut_nxt;
      resetReq_r        <= resetReq_nxt;
      compEnable_r      <= compEnable_nxt;
    end
  end

  // ***************************************************************
  // outputs, all from flops except hresp, tied low
  // ***************************************************************
  assign hreadyout         = hreadyout_r;
  assign hrdata            = hrdata_r;
  assign hresp             = 1'b0;
  assign senseSourceSelect = senseSel_r;
  assign thresholdLevel    = threshold_r;
  assign compEnable        = compEnable_r;
  assign lowSupplyIrq      = irqOut_r;
  assign monitorResetReq   = resetReq_r;

endmodule : svm_monitor_top

// [bench/svm_sva.sv]
`timescale 1ns/1ps
// ***************************************************************
// port checker
// ***************************************************************
module svm_sva #(
  parameter int DIV_BITS = 3
) (
  input logic       mclk,
  input logic       reset,
  input logic       hsel,
  input logic [1:0] htrans,
  input logic       hwrite,
  input logic       hready,
  input logic       hreadyout,
  input logic       compLow,
  input logic [4:0] thresholdLevel,
  input logic       senseSourceSelect,
  input logic       compEnable,
  input logic       lowSupplyIrq,
  input logic       monitorResetReq
);
  logic       wr1;
  logic [7:0] hist;
  wire        act = |hist;
  // recent write or low input; a cause must precede each irq or reset-request rise and each setting change
  always_ff @(posedge mclk) begin
    wr1  <= hsel & hready & htrans[1] & hwrite;
    hist <= reset ? 8'h00 : {hist[6:0], compLow | wr1};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_irq_not_reset: assert property (!(lowSupplyIrq && monitorResetReq))
    else $error("irq and reset request together");
  a_irq_sticky: assert property ($fell(lowSupplyIrq) |-> $past(wr1))
    else $error("irq dropped without a write");
  a_irq_cause: assert property ($rose(lowSupplyIrq) |-> $past(act))
    else $error("irq rose without low input");
  a_reset_cause: assert property ($rose(monitorResetReq) |-> $past(act))
    else $error("reset request without low input");
  a_thr_written: assert property ($changed(thresholdLevel) |-> $past(wr1))
    else $error("threshold changed without write");
  a_src_written: assert property ($changed(senseSourceSelect) |-> $past(wr1))
    else $error("source select changed without write");
  a_en_written: assert property ($changed(compEnable) |-> $past(wr1))
    else $error("enable changed without write");
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase timing wrong");
  c_irq: cover property ($rose(lowSupplyIrq));
  c_rst: cover property ($rose(monitorResetReq));
  c_rd: cover property (hsel && hready && htrans[1] && !hwrite);
endmodule : svm_sva

bind svm_monitor_top svm_sva #(.DIV_BITS(DIV_BITS)) u_sva (.*);

// [bench/svm_comp_model.sv]
`timescale 1ns/1ps
// ***************************************************************
// comparator on supply or sense pin
// ***************************************************************
module svm_comp_model (
  input  logic [4:0] thresholdLevel,
  input  logic       senseSourceSelect,
  input  logic       compEnable,
  input  logic [4:0] supplyLvl,
  input  logic [4:0] pinLvl,
  output logic       compLow
);
  // levels in threshold codes; a disabled comparator never reports low
  assign compLow = compEnable & ((senseSourceSelect ? pinLvl : supplyLvl) < thresholdLevel);
endmodule : svm_comp_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
// ***************************************************************
// bench
// ***************************************************************
module tb_top;
  logic mclk, reset, hsel, hwrite, hreadyout, hresp, compLow, sleepMode, debugMode, rdPh;
  logic senseSourceSelect, compEnable, lowSupplyIrq, monitorResetReq;
  logic [31:0] haddr, hwdata, hrdata, ctl;
  logic [31:0] expQ[$];
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  sourceTick, sourceSleepStop;
  logic [4:0]  thresholdLevel, supplyLvl, pinLvl, thr;
  int          n_mismatch, checks, cyc;
  wire         hready = hreadyout;
  svm_monitor_top DUT (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .compLow(compLow), .sourceTick(sourceTick),
    .sourceSleepStop(sourceSleepStop), .sleepMode(sleepMode), .debugMode(debugMode),
    .senseSourceSelect(senseSourceSelect), .thresholdLevel(thresholdLevel), .compEnable(compEnable),
    .lowSupplyIrq(lowSupplyIrq), .monitorResetReq(monitorResetReq));
  svm_comp_model u_comp (.thresholdLevel(thresholdLevel), .senseSourceSelect(senseSourceSelect),
    .compEnable(compEnable), .supplyLvl(supplyLvl), .pinLvl(pinLvl), .compLow(compLow));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // one single word transfer; address held until hready, then data held until hready
  task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'h1; haddr <= {20'h0, a}; htrans <= svm_pkg::HTRANS_NONSEQ_BIT; hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'h1);
  endtask : ahb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    ahb(a, 1'h0, 32'h0);
  endtask : rd
  // bounded wait for a level, then leave the comparison to the caller
  task automatic waitv(ref logic s, input logic v);
    for (int k = 0; k < 60 && s !== v; k++) @(posedge mclk);
  endtask : waitv
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  // random clock source pulses; cycle ceiling against hangs
  always @(posedge mclk) begin
    sourceTick <= 4'($urandom);
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // read checker: oldest expectation against each finished read data phase
  always @(posedge mclk)
    if (rdPh && hreadyout === 1'h1) begin
      chk(hrdata, expQ.pop_front());
      rdPh = 1'h0;
    end else if (hsel && hready && htrans[1] && !hwrite) rdPh = 1'h1;
  initial begin
    reset = 1'h1; hsel = 1'h0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'h0; hsize = svm_pkg::HSIZE_WORD;
    hwdata = 32'h0; sourceTick = 4'h0; sourceSleepStop = 4'h0; sleepMode = 1'h0; debugMode = 1'h0;
    supplyLvl = 5'h1f; pinLvl = 5'h1f; rdPh = 1'h0; n_mismatch = 0; checks = 0; cyc = 0;
    void'($urandom(32'h603497f0));
    repeat (4) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    rd(svm_pkg::ADDR_CLOCK, 32'h100);
    rd(svm_pkg::ADDR_CONTROL, 32'h0);
    rd(12'h020, 32'h0);
    ahb(svm_pkg::ADDR_CONTROL, 1'h1, 32'hffff);
    rd(svm_pkg::ADDR_CONTROL, 32'h0);
    ahb(svm_pkg::ADDR_PROTECT, 1'h1, {16'h0, svm_pkg::PROTECT_KEY});
    thr = 5'($urandom_range(29, 1));
    ctl = {16'h0, 1'h1, 2'h0, thr, 8'h01};
    ahb(svm_pkg::ADDR_CONTROL, 1'h1, ctl);
    rd(svm_pkg::ADDR_CONTROL, ctl);
    chk({27'h0, thresholdLevel}, {27'h0, thr});
    chk({31'h0, senseSourceSelect}, 32'h1);
    pinLvl <= thr;
    supplyLvl <= 5'h00;
    repeat (20) @(posedge mclk);
    rd(svm_pkg::ADDR_FLAG, 32'h0);
    // gated monitor clock: a low pin must go unseen while debug or sleep holds it
    ahb(svm_pkg::ADDR_CLOCK, 1'h1, 32'h0);
    rd(svm_pkg::ADDR_CLOCK, 32'h0);
    debugMode <= 1'h1;
    @(posedge mclk);
    pinLvl <= 5'h00;
    repeat (20) @(posedge mclk);
    rd(svm_pkg::ADDR_FLAG, 32'h0);
    debugMode <= 1'h0; sleepMode <= 1'h1; sourceSleepStop <= 4'h1;
    repeat (20) @(posedge mclk);
    rd(svm_pkg::ADDR_FLAG, 32'h0);
    ahb(svm_pkg::ADDR_CLOCK, 1'h1, 32'h100);
    sleepMode <= 1'h0; debugMode <= 1'h1; pinLvl <= thr;
    ahb(svm_pkg::ADDR_FLAG, 1'h1, 32'h1);
    ahb(svm_pkg::ADDR_IRQ_EN, 1'h1, 32'h1);
    pinLvl <= thr - 5'h01;
    waitv(lowSupplyIrq, 1'h1);
    chk({31'h0, lowSupplyIrq}, 32'h1);
    rd(svm_pkg::ADDR_FLAG, 32'h101);
    pinLvl <= 5'h1f;
    repeat (20) @(posedge mclk);
    chk({31'h0, lowSupplyIrq}, 32'h1);
    rd(svm_pkg::ADDR_FLAG, 32'h1);
    ahb(svm_pkg::ADDR_FLAG, 1'h1, 32'h1);
    rd(svm_pkg::ADDR_FLAG, 32'h0);
    chk({31'h0, lowSupplyIrq}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      ahb(svm_pkg::ADDR_CONTROL, 1'h1, ctl | 32'(m << 2));
      rd(svm_pkg::ADDR_CONTROL, ctl | 32'(m << 2));
    end
    ahb(svm_pkg::ADDR_CONTROL, 1'h1, ctl | 32'ha0);
    pinLvl <= 5'h00;
    waitv(monitorResetReq, 1'h1);
    chk({31'h0, monitorResetReq}, 32'h1);
    chk({31'h0, lowSupplyIrq}, 32'h0);
    pinLvl <= 5'h1f;
    waitv(monitorResetReq, 1'h0);
    chk({31'h0, monitorResetReq}, 32'h0);
    ahb(svm_pkg::ADDR_PROTECT, 1'h1, 32'h0);
    ahb(svm_pkg::ADDR_CONTROL, 1'h1, 32'h0);
    @(posedge mclk);
    chk({31'h0, compEnable}, 32'h1);
    rd(svm_pkg::ADDR_CONTROL, ctl | 32'ha0);
    summarize();
  end
endmodule : tb_top
